// ### verilog/tsc_pkg.sv
`default_nettype none
package tsc_pkg;
  // register pointer values
  localparam logic [7:0] ADDR_CONFIG = 8'h03;
  localparam logic [7:0] ADDR_UPPER_HI = 8'h04;
  localparam logic [7:0] ADDR_UPPER_LO = 8'h05;
  localparam logic [7:0] ADDR_LOWER_HI = 8'h06;
  localparam logic [7:0] ADDR_LOWER_LO = 8'h07;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // reset values
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] UPPER_RESET = 16'h2000;
  localparam logic [15:0] LOWER_RESET = 16'h0500;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  // configuration field positions
  localparam int FQ_LSB = 0;
  localparam int FQ_MSB = 1;
  localparam int CRIT_POL_BIT = 2;
  localparam int ALARM_POL_BIT = 3;
  localparam int STYLE_BIT = 4;
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 6;
  localparam int RES_BIT = 7;
  // operation modes
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
  localparam logic [1:0] MODE_SPS = 2'h2;
  localparam logic [1:0] MODE_SHUTDOWN = 2'h3;
  // fault counter saturates at the deepest queue
  localparam logic [2:0] FAULT_MAX = 3'h4;
  // low three bits are flags, not value, at 13-bit resolution
  localparam logic [15:0] LOW_RES_MASK = 16'hFFF8;
  // timing
  localparam int unsigned MCLK_HZ = 10_000_000;
  localparam int unsigned CYC_PER_MS = MCLK_HZ / 1000;
  localparam int unsigned ONE_SHOT_MS = 240;
  localparam int unsigned SPS_CONV_MS = 60;
  localparam int unsigned SPS_PERIOD_MS = 1000;
  localparam int CNT_W = 24;
  typedef enum logic [1:0] {
    TSC_IDLE = 2'b00,
    TSC_CONVERT = 2'b01,
    TSC_WAIT = 2'b10
  } tsc_seq_e;
endpackage
`default_nettype wire

// ### verilog/tsc_conv_seq.sv
`default_nettype none
module tsc_conv_seq #(
  parameter int unsigned CONV_CYCLES = 2_400_000,
  parameter int unsigned SPS_CONV_CYCLES = 600_000,
  parameter int unsigned SPS_PERIOD_CYCLES = 10_000_000
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] mode,
  input wire logic mode_written,
  output logic adc_run,
  output logic sample
);
  typedef struct packed {
    tsc_pkg::tsc_seq_e state;
    logic [tsc_pkg::CNT_W-1:0] count;
    logic sample;
  } tsc_seq_s;

  tsc_seq_s s;
  tsc_seq_s next_s;

  function automatic logic [tsc_pkg::CNT_W-1:0] conv_len(input logic [1:0] m);
    if (m == tsc_pkg::MODE_SPS) begin
      conv_len = tsc_pkg::CNT_W'(SPS_CONV_CYCLES - 1);
    end else begin
      conv_len = tsc_pkg::CNT_W'(CONV_CYCLES - 1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.sample = 1'b0;
    if (mode_written) begin
      // a config write restarts the sequence; one-shot starts only here
      next_s.state = tsc_pkg::TSC_IDLE;
      if (mode != tsc_pkg::MODE_SHUTDOWN) begin
        next_s.state = tsc_pkg::TSC_CONVERT;
        next_s.count = conv_len(mode);
      end
    end else begin
      case (s.state)
        tsc_pkg::TSC_IDLE: begin
          if (mode == tsc_pkg::MODE_CONT || mode == tsc_pkg::MODE_SPS) begin
            next_s.state = tsc_pkg::TSC_CONVERT;
            next_s.count = conv_len(mode);
          end
        end
        tsc_pkg::TSC_CONVERT: begin
          if (s.count == '0) begin
            next_s.sample = 1'b1;
            if (mode == tsc_pkg::MODE_CONT) begin
              next_s.count = conv_len(mode);
            end else if (mode == tsc_pkg::MODE_SPS) begin
              next_s.state = tsc_pkg::TSC_WAIT;
              next_s.count = tsc_pkg::CNT_W'(SPS_PERIOD_CYCLES - SPS_CONV_CYCLES - 1);
            end else begin
              next_s.state = tsc_pkg::TSC_IDLE;
            end
          end else begin
            next_s.count = s.count - 1'b1;
          end
        end
        tsc_pkg::TSC_WAIT: begin
          if (s.count == '0) begin
            next_s.state = tsc_pkg::TSC_CONVERT;
            next_s.count = conv_len(mode);
          end else begin
            next_s.count = s.count - 1'b1;
          end
        end
        default: next_s.state = tsc_pkg::TSC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s.state <= tsc_pkg::TSC_IDLE;
      s.count <= '0;
      s.sample <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign adc_run = (s.state == tsc_pkg::TSC_CONVERT);
  assign sample = s.sample;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_shutdown_idle: assert property (mode == tsc_pkg::MODE_SHUTDOWN |=> !adc_run)
    else $error("converter runs in shutdown");
  a_one_shot_stop: assert property (
    s.sample && !mode_written && mode == tsc_pkg::MODE_ONE_SHOT
    |-> s.state == tsc_pkg::TSC_IDLE)
    else $error("one-shot kept converting");
  a_cont_restart: assert property (
    s.sample && !mode_written && mode == tsc_pkg::MODE_CONT |-> adc_run)
    else $error("continuous mode did not restart");
  a_sps_gap: assert property (
    s.sample && !mode_written && mode == tsc_pkg::MODE_SPS
    |-> s.state == tsc_pkg::TSC_WAIT)
    else $error("one per second mode did not idle");
  c_sps_wait: cover property (s.state == tsc_pkg::TSC_WAIT ##1 s.state == tsc_pkg::TSC_CONVERT);
endmodule // tsc_conv_seq
`default_nettype wire

// ### verilog/tsc_limits.sv
// Summary of operation
// - fault-queue code 00..11 needs 1..4 consecutive faults before alarms assert
// - faults accumulate to the selected count so noise cannot trigger alarms
// - config bit 2 sets critical output level; 0 low, 1 high, reset 0
// - config bit 3 sets alarm output level; 0 low, 1 high, reset 0
// - config bit 4 picks style for both outputs; 0 interrupt, 1 comparator
// - mode 00 converts continuously, restarting right after each result
// - mode 01 runs a single 240 ms conversion then stops
// - mode 10 converts 60 ms once per second and idles between
// - mode 11 stops conversions while register access keeps working
// - config bit 7 picks 13-bit or 16-bit result resolution
// - result strictly above upper limit is an overtemperature fault
// - overtemperature drives the alarm output through queue, level and style
// - result strictly below lower limit is an undertemperature fault
// - undertemperature drives the alarm output through queue, level and style
// - limits are 16-bit twos complement, compared signed
// - upper limit high byte at 0x04, pointer auto-increments to 0x05
// - lower limit high byte at 0x06, pointer auto-increments to 0x07
// - upper limit resets to the 64 C code
// - lower limit resets to the 10 C code
// - hysteresis 0..15 C moves upper and critical down, lower up, for release
// - in one-shot and per-second modes a mode write returns done flag high
`default_nettype none
module tsc_limits #(
  parameter int unsigned CONV_CYCLES = tsc_pkg::ONE_SHOT_MS * tsc_pkg::CYC_PER_MS,
  parameter int unsigned SPS_CONV_CYCLES = tsc_pkg::SPS_CONV_MS * tsc_pkg::CYC_PER_MS,
  parameter int unsigned SPS_PERIOD_CYCLES = tsc_pkg::SPS_PERIOD_MS * tsc_pkg::CYC_PER_MS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic reg_ptr_load,
  input wire logic [7:0] reg_ptr_value,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd,
  output logic [7:0] reg_rd_data,
  input wire logic temp_read,
  input wire logic status_read,
  input wire logic [15:0] adc_value,
  input wire logic [15:0] critical_limit,
  input wire logic [3:0] hysteresis,
  output logic adc_run,
  output logic adc_high_res,
  output logic [15:0] temp_result,
  output logic conv_done_n,
  output logic alarm_pin_o,
  output logic alarm_pin_oe,
  output logic critical_output_o,
  output logic critical_output_oe
);
  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] cfg;
    logic [15:0] upper;
    logic [15:0] lower;
    logic [7:0] rd_data;
    logic [15:0] result;
    logic rdy_n;
    logic [2:0] int_cnt;
    logic [2:0] crit_cnt;
    logic int_act;
    logic crit_act;
  } tsc_lim_s;

  tsc_lim_s s;
  tsc_lim_s next_s;
  logic sample;
  logic access;
  logic cfg_wr;
  logic [15:0] masked;
  logic signed [16:0] res_sx;
  logic signed [16:0] hyst_sx;
  logic over;
  logic under;
  logic crit_over;
  logic in_band;
  logic crit_clear;
  logic [2:0] int_next_cnt;
  logic [2:0] crit_next_cnt;
  logic int_hit;
  logic crit_hit;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic signed [16:0] sx(input logic [15:0] v);
    sx = $signed({v[15], v});
  endfunction

  function automatic logic [2:0] count_fault(input logic [2:0] cnt, input logic out);
    if (!out) begin
      count_fault = 3'h0;
    end else if (cnt == tsc_pkg::FAULT_MAX) begin
      count_fault = cnt;
    end else begin
      count_fault = cnt + 3'h1;
    end
  endfunction

  function automatic logic pin_level(input logic act, input logic pol);
    pin_level = act ? pol : ~pol;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  tsc_conv_seq #(
    .CONV_CYCLES(CONV_CYCLES),
    .SPS_CONV_CYCLES(SPS_CONV_CYCLES),
    .SPS_PERIOD_CYCLES(SPS_PERIOD_CYCLES)
  ) u_seq (
    .mclk(mclk),
    .nrst(nrst),
    // next value, so a config write restarts the sequencer in the new mode
    .mode(next_s.cfg[tsc_pkg::MODE_MSB:tsc_pkg::MODE_LSB]),
    .mode_written(cfg_wr),
    .adc_run(adc_run),
    .sample(sample)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pointer load wins; a data access in the same cycle is dropped
  assign access = (reg_rd || reg_wr) && !reg_ptr_load;
  assign cfg_wr = reg_wr && !reg_ptr_load && (s.ptr == tsc_pkg::ADDR_CONFIG);

  // 13-bit mode: low three bits carry flags elsewhere, so compare without them
  assign masked = s.cfg[tsc_pkg::RES_BIT] ? adc_value
                                          : (adc_value & tsc_pkg::LOW_RES_MASK);
  assign res_sx = sx(masked);
  assign hyst_sx = sx({5'h00, hysteresis, 7'h00});
  // 17-bit arithmetic keeps limit plus hysteresis from wrapping
  assign over = res_sx > sx(s.upper);
  assign under = res_sx < sx(s.lower);
  assign crit_over = res_sx > sx(critical_limit);
  assign in_band = (res_sx <= sx(s.upper) - hyst_sx)
                && (res_sx >= sx(s.lower) + hyst_sx);
  assign crit_clear = res_sx <= sx(critical_limit) - hyst_sx;

  assign int_next_cnt = count_fault(s.int_cnt, over || under);
  assign crit_next_cnt = count_fault(s.crit_cnt, crit_over);
  assign int_hit = int_next_cnt > {1'b0, s.cfg[tsc_pkg::FQ_MSB:tsc_pkg::FQ_LSB]};
  assign crit_hit = crit_next_cnt > {1'b0, s.cfg[tsc_pkg::FQ_MSB:tsc_pkg::FQ_LSB]};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    // register port
    if (reg_ptr_load) begin
      next_s.ptr = reg_ptr_value;
    end else if (access) begin
      next_s.ptr = s.ptr + 8'h01;
    end
    if (reg_rd && !reg_ptr_load) begin
      case (s.ptr)
        tsc_pkg::ADDR_CONFIG: next_s.rd_data = s.cfg;
        tsc_pkg::ADDR_UPPER_HI: next_s.rd_data = s.upper[15:8];
        tsc_pkg::ADDR_UPPER_LO: next_s.rd_data = s.upper[7:0];
        tsc_pkg::ADDR_LOWER_HI: next_s.rd_data = s.lower[15:8];
        tsc_pkg::ADDR_LOWER_LO: next_s.rd_data = s.lower[7:0];
        default: next_s.rd_data = tsc_pkg::RD_UNMAPPED;
      endcase
    end
    if (reg_wr && !reg_ptr_load) begin
      case (s.ptr)
        tsc_pkg::ADDR_CONFIG: next_s.cfg = reg_wr_data;
        tsc_pkg::ADDR_UPPER_HI: next_s.upper[15:8] = reg_wr_data;
        tsc_pkg::ADDR_UPPER_LO: next_s.upper[7:0] = reg_wr_data;
        tsc_pkg::ADDR_LOWER_HI: next_s.lower[15:8] = reg_wr_data;
        tsc_pkg::ADDR_LOWER_LO: next_s.lower[7:0] = reg_wr_data;
        default: next_s.ptr = next_s.ptr;
      endcase
    end

    // conversion-done flag: a new result wins over either release
    if (temp_read) begin
      next_s.rdy_n = 1'b1;
    end
    if (cfg_wr && (reg_wr_data[tsc_pkg::MODE_MSB:tsc_pkg::MODE_LSB] == tsc_pkg::MODE_ONE_SHOT
        || reg_wr_data[tsc_pkg::MODE_MSB:tsc_pkg::MODE_LSB] == tsc_pkg::MODE_SPS)) begin
      next_s.rdy_n = 1'b1;
    end

    // release paths first so that a same-cycle fault set wins
    if (s.cfg[tsc_pkg::STYLE_BIT]) begin
      if (sample && in_band) begin
        next_s.int_act = 1'b0;
      end
      if (sample && crit_clear) begin
        next_s.crit_act = 1'b0;
      end
    end else if (status_read) begin
      next_s.int_act = 1'b0;
      next_s.crit_act = 1'b0;
    end

    if (sample) begin
      next_s.result = masked;
      next_s.rdy_n = 1'b0;
      next_s.int_cnt = int_next_cnt;
      next_s.crit_cnt = crit_next_cnt;
      if (int_hit) begin
        next_s.int_act = 1'b1;
      end
      if (crit_hit) begin
        next_s.crit_act = 1'b1;
      end
    end
    // a config rewrite restarts the queue count
    if (cfg_wr) begin
      next_s.int_cnt = 3'h0;
      next_s.crit_cnt = 3'h0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s.ptr <= tsc_pkg::PTR_RESET;
      s.cfg <= tsc_pkg::CONFIG_RESET;
      s.upper <= tsc_pkg::UPPER_RESET;
      s.lower <= tsc_pkg::LOWER_RESET;
      s.rd_data <= tsc_pkg::RD_UNMAPPED;
      s.result <= tsc_pkg::RESULT_RESET;
      s.rdy_n <= 1'b1;
      s.int_cnt <= 3'h0;
      s.crit_cnt <= 3'h0;
      s.int_act <= 1'b0;
      s.crit_act <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // open drain: the pin is pulled low while enabled, released when high
  assign reg_rd_data = s.rd_data;
  assign temp_result = s.result;
  assign conv_done_n = s.rdy_n;
  assign adc_high_res = s.cfg[tsc_pkg::RES_BIT];
  assign alarm_pin_o = 1'b0;
  assign alarm_pin_oe = ~pin_level(s.int_act, s.cfg[tsc_pkg::ALARM_POL_BIT]);
  assign critical_output_o = 1'b0;
  assign critical_output_oe = ~pin_level(s.crit_act, s.cfg[tsc_pkg::CRIT_POL_BIT]);

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  a_reset_limits: assert property ($past(nrst) == 1'b0 |->
    s.upper == 16'h2000 && s.lower == 16'h0500 && s.cfg == 8'h00)
    else $error("limit reset values wrong");
  a_single_fault: assert property (sample && s.cfg[1:0] == 2'b00 && (over || under)
    |=> s.int_act)
    else $error("single fault did not raise alarm");
  a_queue_four: assert property (sample && s.cfg[1:0] == 2'b11 && s.int_cnt == 3'h0
    && !s.int_act |=> !s.int_act)
    else $error("alarm raised before four faults");
  a_over_counts: assert property (sample && over && !cfg_wr |=> s.int_cnt != 3'h0)
    else $error("overtemperature not counted");
  a_under_counts: assert property (sample && under && !cfg_wr |=> s.int_cnt != 3'h0)
    else $error("undertemperature not counted");
  a_alarm_low: assert property ($rose(s.int_act) && !s.cfg[3] |-> alarm_pin_oe)
    else $error("active-low alarm not pulled");
  a_crit_high: assert property ($rose(s.crit_act) && s.cfg[2] |-> !critical_output_oe)
    else $error("active-high critical output pulled");
  a_irq_latch: assert property (!s.cfg[4] && s.int_act && !status_read |=> s.int_act)
    else $error("interrupt style alarm dropped early");
  a_cmp_release: assert property (s.cfg[4] && s.int_act && sample && in_band && !int_hit
    |=> !s.int_act)
    else $error("comparator alarm not released");
  a_ptr_incr: assert property (access |=> s.ptr == $past(s.ptr) + 8'h01)
    else $error("pointer did not auto-increment");
  a_lower_pair: assert property (reg_rd && !reg_ptr_load && s.ptr == 8'h06
    ##1 reg_rd && !reg_ptr_load |=> reg_rd_data == s.lower[7:0])
    else $error("lower limit pair read wrong");
  a_done_release: assert property (cfg_wr && reg_wr_data[6:5] == 2'b01 && !sample
    |=> conv_done_n)
    else $error("done flag not released on mode write");
  a_done_set: assert property (sample |=> !conv_done_n)
    else $error("done flag not set by result");

  c_alarm_raised: cover property (sample ##1 s.int_act);
  c_crit_cmp: cover property (s.crit_act && s.cfg[4]);
  c_upper_pair: cover property (reg_rd && s.ptr == 8'h04 ##1 reg_rd && s.ptr == 8'h05);
  c_status_clear: cover property (s.int_act && status_read && !s.cfg[4] ##1 !s.int_act);
endmodule // tsc_limits
`default_nettype wire

// ### bench/tsc_host_model.sv
`default_nettype none
module tsc_host_model (
  input wire logic mclk,
  output logic reg_ptr_load,
  output logic [7:0] reg_ptr_value,
  output logic reg_wr,
  output logic [7:0] reg_wr_data,
  output logic reg_rd,
  input wire logic [7:0] reg_rd_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    reg_ptr_load = 1'b0;
    reg_ptr_value = 8'hFF;
    reg_wr = 1'b0;
    reg_wr_data = 8'hFF;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // entered and left at a falling edge; released data lines show the
  // inverse of the last byte so a stale value cannot pass for a good one
  task automatic set_ptr(input logic [7:0] a);
    reg_ptr_load = 1'b1;
    reg_ptr_value = a;
    @(negedge mclk);
    reg_ptr_load = 1'b0;
    reg_ptr_value = ~a;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    reg_wr = 1'b1;
    reg_wr_data = d;
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wr_data = ~d;
  endtask
  task automatic rd_byte(output logic [7:0] d);
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    d = reg_rd_data;
  endtask
  // only the high byte address is loaded; the low byte follows by increment
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    set_ptr(a);
    // strobe held across both bytes rather than dropped and raised at once
    reg_wr = 1'b1;
    reg_wr_data = v[15:8];
    @(negedge mclk);
    reg_wr_data = v[7:0];
    @(negedge mclk);
    reg_wr = 1'b0;
    reg_wr_data = ~v[7:0];
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] v);
    set_ptr(a);
    reg_rd = 1'b1;
    @(negedge mclk);
    v[15:8] = reg_rd_data;
    @(negedge mclk);
    v[7:0] = reg_rd_data;
    reg_rd = 1'b0;
  endtask
endmodule // tsc_host_model
`default_nettype wire

// ### bench/temp_sensor_config_and_limits_bench.sv
`default_nettype none
module temp_sensor_config_and_limits_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int CONV = 20;
  localparam int SPS_CONV = 10;
  localparam int SPS_PERIOD = 40;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic reg_ptr_load, reg_wr, reg_rd;
  logic [7:0] reg_ptr_value, reg_wr_data, reg_rd_data;
  logic temp_read = 1'b0;
  logic status_read = 1'b0;
  // in band from the start so no alarm latches before the first scenario
  logic [15:0] adc_value = 16'h1000;
  logic [15:0] critical_limit = 16'h4980;
  logic [3:0] hysteresis = 4'h0;
  logic adc_run, adc_high_res, conv_done_n;
  logic [15:0] temp_result;
  logic alarm_pin_o, alarm_pin_oe, critical_output_o, critical_output_oe;
  int mismatches = 0;
  int n_compared = 0;
  always #50 mclk = ~mclk;
  tsc_host_model host_u (.mclk(mclk), .reg_ptr_load(reg_ptr_load),
    .reg_ptr_value(reg_ptr_value), .reg_wr(reg_wr), .reg_wr_data(reg_wr_data),
    .reg_rd(reg_rd), .reg_rd_data(reg_rd_data));
  tsc_limits #(.CONV_CYCLES(CONV), .SPS_CONV_CYCLES(SPS_CONV),
    .SPS_PERIOD_CYCLES(SPS_PERIOD)) dut_u (.mclk(mclk), .nrst(nrst),
    .reg_ptr_load(reg_ptr_load), .reg_ptr_value(reg_ptr_value), .reg_wr(reg_wr),
    .reg_wr_data(reg_wr_data), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
    .temp_read(temp_read), .status_read(status_read), .adc_value(adc_value),
    .critical_limit(critical_limit), .hysteresis(hysteresis), .adc_run(adc_run),
    .adc_high_res(adc_high_res), .temp_result(temp_result), .conv_done_n(conv_done_n),
    .alarm_pin_o(alarm_pin_o), .alarm_pin_oe(alarm_pin_oe),
    .critical_output_o(critical_output_o), .critical_output_oe(critical_output_oe));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pulse_read();
    temp_read = 1'b1;
    @(negedge mclk);
    temp_read = 1'b0;
  endtask
  // a bounded wait: a missing sample counts as a mismatch, not a hang
  task automatic wait_done(input bit rel);
    int n;
    n = 0;
    while (conv_done_n !== 1'b0 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    chk("conv_done_n", 16'h0000, {15'h0, conv_done_n});
    if (rel) begin
      pulse_read();
    end
  endtask
  // the read pulse drops any stale result flag so the next low is fresh
  task automatic set_cfg(input logic [7:0] v);
    host_u.set_ptr(tsc_pkg::ADDR_CONFIG);
    host_u.wr_byte(v);
    pulse_read();
  endtask
  task automatic expect_alarm(input logic [15:0] t, input logic oe);
    adc_value = t;
    wait_done(1'b1);
    chk("alarm_pin_oe", {15'h0, oe}, {15'h0, alarm_pin_oe});
  endtask
  task automatic gap(output int c, output int hi);
    c = 0;
    hi = 0;
    while (conv_done_n !== 1'b0 && c < 200) begin
      @(negedge mclk);
      c++;
      if (adc_run === 1'b1) begin
        hi++;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [7:0] d;
    logic [15:0] w;
    chk("alarm_pin_oe", 16'h0000, {15'h0, alarm_pin_oe});
    chk("critical_output_oe", 16'h0000, {15'h0, critical_output_oe});
    host_u.set_ptr(tsc_pkg::ADDR_CONFIG);
    host_u.rd_byte(d);
    chk("config", 16'h0000, {8'h00, d});
    host_u.rd16(tsc_pkg::ADDR_UPPER_HI, w);
    chk("upper", 16'h2000, w);
    host_u.rd16(tsc_pkg::ADDR_LOWER_HI, w);
    chk("lower", 16'h0500, w);
    host_u.wr16(tsc_pkg::ADDR_UPPER_HI, 16'h3A5C);
    host_u.rd16(tsc_pkg::ADDR_UPPER_HI, w);
    chk("upper", 16'h3A5C, w);
    host_u.set_ptr(8'h0C);
    host_u.wr_byte(8'hA5);
    host_u.set_ptr(8'h0C);
    host_u.rd_byte(d);
    chk("unmapped", 16'h0000, {8'h00, d});
    host_u.wr16(tsc_pkg::ADDR_UPPER_HI, 16'h2000);
  endtask
  task automatic t_int();
    set_cfg(8'h00);
    expect_alarm(16'h2000, 1'b0);
    expect_alarm(16'h2008, 1'b1);
    expect_alarm(16'h1000, 1'b1);
    chk("alarm_pin_o", 16'h0000, {15'h0, alarm_pin_o});
    status_read = 1'b1;
    @(negedge mclk);
    status_read = 1'b0;
    chk("alarm_pin_oe", 16'h0000, {15'h0, alarm_pin_oe});
  endtask
  task automatic t_queue();
    for (int q = 0; q < 4; q++) begin
      set_cfg(8'h10 | 8'(q));
      for (int i = 0; i <= q; i++) begin
        expect_alarm(16'h2008, 1'(i == q));
      end
      expect_alarm(16'h1000, 1'b0);
    end
    set_cfg(8'h11);
    expect_alarm(16'h2008, 1'b0);
    expect_alarm(16'h1000, 1'b0);
    expect_alarm(16'h2008, 1'b0);
    expect_alarm(16'h2008, 1'b1);
    expect_alarm(16'h1000, 1'b0);
  endtask
  task automatic t_hyst();
    hysteresis = 4'h1;
    set_cfg(8'h18);
    chk("alarm_pin_oe", 16'h0001, {15'h0, alarm_pin_oe});
    expect_alarm(16'h2008, 1'b0);
    expect_alarm(16'h1F88, 1'b0);
    expect_alarm(16'h1F80, 1'b1);
    hysteresis = 4'h0;
  endtask
  task automatic t_low();
    logic [15:0] w;
    set_cfg(8'h10);
    host_u.wr16(tsc_pkg::ADDR_LOWER_HI, 16'hFF00);
    host_u.rd16(tsc_pkg::ADDR_LOWER_HI, w);
    chk("lower", 16'hFF00, w);
    expect_alarm(16'h0100, 1'b0);
    expect_alarm(16'hFF00, 1'b0);
    expect_alarm(16'hFE00, 1'b1);
    expect_alarm(16'h1000, 1'b0);
    host_u.wr16(tsc_pkg::ADDR_LOWER_HI, 16'h0500);
  endtask
  task automatic t_crit();
    set_cfg(8'h14);
    chk("critical_output_oe", 16'h0001, {15'h0, critical_output_oe});
    expect_alarm(16'h4980, 1'b1);
    chk("critical_output_oe", 16'h0001, {15'h0, critical_output_oe});
    expect_alarm(16'h4988, 1'b1);
    chk("critical_output_oe", 16'h0000, {15'h0, critical_output_oe});
    chk("critical_output_o", 16'h0000, {15'h0, critical_output_o});
    expect_alarm(16'h1000, 1'b0);
    chk("critical_output_oe", 16'h0001, {15'h0, critical_output_oe});
  endtask
  task automatic t_res();
    set_cfg(8'h80);
    adc_value = 16'h0107;
    wait_done(1'b1);
    chk("temp_result", 16'h0107, temp_result);
    chk("adc_high_res", 16'h0001, {15'h0, adc_high_res});
    set_cfg(8'h00);
    wait_done(1'b1);
    chk("temp_result", 16'h0100, temp_result);
    chk("adc_high_res", 16'h0000, {15'h0, adc_high_res});
  endtask
  task automatic t_modes();
    int c;
    int hi;
    logic [15:0] w;
    wait_done(1'b1);
    gap(c, hi);
    chk("continuous period", 16'(CONV), 16'(c + 1));
    set_cfg(8'h40);
    wait_done(1'b1);
    gap(c, hi);
    chk("per-second period", 16'(SPS_PERIOD), 16'(c + 1));
    chk("per-second busy", 16'(SPS_CONV), 16'(hi));
    set_cfg(8'h60);
    gap(c, hi);
    chk("shutdown busy", 16'h0000, 16'(hi));
    chk("shutdown idle", 16'd200, 16'(c));
    host_u.rd16(tsc_pkg::ADDR_UPPER_HI, w);
    chk("upper", 16'h2000, w);
    set_cfg(8'h20);
    wait_done(1'b0);
    hi = 0;
    repeat (60) begin
      @(negedge mclk);
      hi += int'(adc_run === 1'b1);
    end
    chk("one-shot rerun", 16'h0000, 16'(hi));
    host_u.set_ptr(tsc_pkg::ADDR_CONFIG);
    host_u.wr_byte(8'h20);
    chk("conv_done_n", 16'h0001, {15'h0, conv_done_n});
    wait_done(1'b1);
    set_cfg(8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // the full sequence needs roughly 1200 cycles; the limit leaves wide margin
  initial begin
    #3_000_000;
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (16) @(negedge mclk);
    nrst = 1'b1;
    @(negedge mclk);
    t_regs();
    t_int();
    t_queue();
    t_hyst();
    t_low();
    t_crit();
    t_res();
    t_modes();
    stop_test();
  end
endmodule // temp_sensor_config_and_limits_bench
`default_nettype wire
